/* File: shared/pin_mux_pkg.sv */
// Behaviour
// - port C control clears on reset and standby
// - registers clear on hardware standby
// - reserved bits read zero, ignore writes
// - C4 selects general I/O or interrupt
// - C3 selects general I/O or serial2 receive
// - C2 selects general I/O or serial2 transmit
// - C1 selects general I/O or serial1 receive
// - C0 selects general I/O or serial1 transmit
// - D direction bits 13..0 map pins
// - D direction one output, zero input
// - D direction only in GPIO/timer function
// - D direction clears on non-watchdog reset
// - both D control registers clear on reset
// - high register pins 13..8, low 7..0
// - D13 field selects GPIO, pulse6, CAN
// - D12 selects GPIO or pulse output 4
// - D11 selects GPIO or pulse output 3
// - D10 selects GPIO or pulse output 2
// - D9 selects GPIO or pulse output 1
// - D8 selects GPIO or pulse output 0
// - C direction active in general I/O
`default_nettype none
package pin_mux_pkg;
   localparam logic [2:0] ADDR_PORT_C_DIRECTION = 3'h0;
   localparam logic [2:0] ADDR_PORT_C_FUNCTION_CONTROL = 3'h1;
   localparam logic [2:0] ADDR_PORT_D_DIRECTION = 3'h2;
   localparam logic [2:0] ADDR_PORT_D_FUNCTION_CONTROL_HIGH = 3'h3;
   localparam logic [2:0] ADDR_PORT_D_FUNCTION_CONTROL_LOW = 3'h4;
   localparam logic [15:0] RESET_VALUE = 16'h0000;
   localparam logic [15:0] MASK_PORT_C_DIRECTION = 16'h001f;
   localparam logic [15:0] MASK_PORT_C_FUNCTION_CONTROL = 16'h0155;
   localparam logic [15:0] MASK_PORT_D_DIRECTION = 16'h3fff;
   localparam logic [15:0] MASK_PORT_D_FUNCTION_CONTROL_HIGH = 16'h0d55;
   localparam logic [15:0] MASK_PORT_D_FUNCTION_CONTROL_LOW = 16'h5555;
   localparam int POS_C4 = 8;
   localparam int POS_C3 = 6;
   localparam int POS_C2 = 4;
   localparam int POS_C1 = 2;
   localparam int POS_C0 = 0;
   localparam int POS_D13_HI = 11;
   localparam int POS_D13_LO = 10;
   localparam int POS_D12 = 8;
   localparam int POS_D11 = 6;
   localparam int POS_D10 = 4;
   localparam int POS_D9 = 2;
   localparam int POS_D8 = 0;
   localparam int PORT_C_PINS = 5;
   localparam int PORT_D_PINS = 14;
   localparam int PORT_D_HIGH_PINS = 6;
   localparam int PORT_D_LOW_PINS = 8;
   typedef enum logic [1:0] {
      D13_GPIO = 2'b00,
      D13_PULSE6 = 2'b01,
      D13_CAN = 2'b10,
      D13_RESERVED = 2'b11
   } d13_function_t;
endpackage
`default_nettype wire

/* File: src/port_c_d_pin_function_select.sv */
`timescale 1ns/10ps
`default_nettype none
module port_c_d_pin_function_select
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // hardware standby clears registers
   input wire logic hw_standby,
   // register port
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // port C gpio side
   input wire logic [4:0] port_c_gpio_out,
   output logic [4:0] port_c_gpio_in,
   // port C pads
   input wire logic [4:0] port_c_pad_in,
   output logic [4:0] port_c_pad_out,
   output logic [4:0] port_c_pad_oe,
   // port C peripherals
   output logic external_interrupt_in_0,
   output logic serial1_receive_in,
   output logic serial2_receive_in,
   input wire logic serial1_transmit_out,
   input wire logic serial2_transmit_out,
   // port D gpio side
   input wire logic [13:0] port_d_gpio_out,
   output logic [13:0] port_d_gpio_in,
   // port D timer io, pins 7..0
   input wire logic [7:0] timer_io_out,
   output logic [7:0] timer_io_in,
   // port D pulse and can outputs
   input wire logic [6:0] pulse_ctrl_out,
   input wire logic can_transmit_out,
   // port D pads
   input wire logic [13:0] port_d_pad_in,
   output logic [13:0] port_d_pad_out,
   output logic [13:0] port_d_pad_oe
);
   logic [15:0] port_c_direction;
   logic [15:0] port_c_function_control;
   logic [15:0] port_d_direction;
   logic [15:0] port_d_function_control_high;
   logic [15:0] port_d_function_control_low;
   logic [15:0] next_rdata;
   logic [15:0] c_func_store;
   logic [15:0] dh_func_store;
   logic [4:0] c_sel;
   logic [13:0] d_sel;
   logic [13:0] d_periph_out;
   logic [1:0] pin_d13_function_sel;
   wire wr_c_dir = wr && (addr == pin_mux_pkg::ADDR_PORT_C_DIRECTION);
   wire wr_c_func = wr && (addr == pin_mux_pkg::ADDR_PORT_C_FUNCTION_CONTROL);
   wire wr_d_dir = wr && (addr == pin_mux_pkg::ADDR_PORT_D_DIRECTION);
   wire wr_d_hi = wr && (addr == pin_mux_pkg::ADDR_PORT_D_FUNCTION_CONTROL_HIGH);
   wire wr_d_lo = wr && (addr == pin_mux_pkg::ADDR_PORT_D_FUNCTION_CONTROL_LOW);

   assign c_func_store = wdata & pin_mux_pkg::MASK_PORT_C_FUNCTION_CONTROL;
   assign dh_func_store = wdata & pin_mux_pkg::MASK_PORT_D_FUNCTION_CONTROL_HIGH;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         port_c_function_control <= pin_mux_pkg::RESET_VALUE;
      else if (hw_standby)
         port_c_function_control <= pin_mux_pkg::RESET_VALUE;
      else if (wr_c_func)
         port_c_function_control <= c_func_store;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         port_c_direction <= pin_mux_pkg::RESET_VALUE;
      else if (hw_standby)
         port_c_direction <= pin_mux_pkg::RESET_VALUE;
      else if (wr_c_dir)
         port_c_direction <= wdata & pin_mux_pkg::MASK_PORT_C_DIRECTION;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         port_d_direction <= pin_mux_pkg::RESET_VALUE;
      else if (hw_standby)
         port_d_direction <= pin_mux_pkg::RESET_VALUE;
      else if (wr_d_dir)
         port_d_direction <= wdata & pin_mux_pkg::MASK_PORT_D_DIRECTION;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_d_function_control_high <= pin_mux_pkg::RESET_VALUE;
         port_d_function_control_low <= pin_mux_pkg::RESET_VALUE;
      end
      else if (hw_standby)
      begin
         port_d_function_control_high <= pin_mux_pkg::RESET_VALUE;
         port_d_function_control_low <= pin_mux_pkg::RESET_VALUE;
      end
      else
      begin
         if (wr_d_hi)
            port_d_function_control_high <= dh_func_store;
         if (wr_d_lo)
            port_d_function_control_low <=
               wdata & pin_mux_pkg::MASK_PORT_D_FUNCTION_CONTROL_LOW;
      end
   end

   // read mux, unmapped reads zero
   always_comb
   begin
      next_rdata = 16'h0000;
      if (rd)
      begin
         unique case (addr)
            pin_mux_pkg::ADDR_PORT_C_DIRECTION: next_rdata = port_c_direction;
            pin_mux_pkg::ADDR_PORT_C_FUNCTION_CONTROL: next_rdata = port_c_function_control;
            pin_mux_pkg::ADDR_PORT_D_DIRECTION: next_rdata = port_d_direction;
            pin_mux_pkg::ADDR_PORT_D_FUNCTION_CONTROL_HIGH:
               next_rdata = port_d_function_control_high;
            pin_mux_pkg::ADDR_PORT_D_FUNCTION_CONTROL_LOW:
               next_rdata = port_d_function_control_low;
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= 16'h0000;
      else
         rdata <= next_rdata;
   end

   // port C function selects
   // C4 interrupt select
   assign c_sel[4] = port_c_function_control[pin_mux_pkg::POS_C4];
   assign c_sel[3] = port_c_function_control[pin_mux_pkg::POS_C3];
   assign c_sel[2] = port_c_function_control[pin_mux_pkg::POS_C2];
   assign c_sel[1] = port_c_function_control[pin_mux_pkg::POS_C1];
   assign c_sel[0] = port_c_function_control[pin_mux_pkg::POS_C0];

   // peripheral inputs from pads, idle high
   assign external_interrupt_in_0 = c_sel[4] ? port_c_pad_in[4] : 1'b1;
   assign serial2_receive_in = c_sel[3] ? port_c_pad_in[3] : 1'b1;
   assign serial1_receive_in = c_sel[1] ? port_c_pad_in[1] : 1'b1;

   genvar i;
   generate
      for (i = 0; i < pin_mux_pkg::PORT_C_PINS; i++)
      begin : g_port_c
         logic is_tx;
         logic tx_val;
         assign is_tx = (i == 0) || (i == 2);
         assign tx_val = (i == 0) ? serial1_transmit_out : serial2_transmit_out;
         assign port_c_gpio_in[i] = port_c_pad_in[i];
         assign port_c_pad_oe[i] = c_sel[i] ? is_tx : port_c_direction[i];
         assign port_c_pad_out[i] = (c_sel[i] && is_tx) ? tx_val : port_c_gpio_out[i];
      end
   endgenerate

   assign pin_d13_function_sel =
      port_d_function_control_high[pin_mux_pkg::POS_D13_HI:pin_mux_pkg::POS_D13_LO];
   assign d_sel[13] = (pin_d13_function_sel != pin_mux_pkg::D13_GPIO);
   // reserved code treated as can output
   assign d_periph_out[13] = (pin_d13_function_sel == pin_mux_pkg::D13_PULSE6) ?
      pulse_ctrl_out[6] : can_transmit_out;
   assign d_sel[12] = port_d_function_control_high[pin_mux_pkg::POS_D12];
   assign d_periph_out[12] = pulse_ctrl_out[4];
   assign d_sel[11] = port_d_function_control_high[pin_mux_pkg::POS_D11];
   assign d_periph_out[11] = pulse_ctrl_out[3];
   assign d_sel[10] = port_d_function_control_high[pin_mux_pkg::POS_D10];
   assign d_periph_out[10] = pulse_ctrl_out[2];
   assign d_sel[9] = port_d_function_control_high[pin_mux_pkg::POS_D9];
   assign d_periph_out[9] = pulse_ctrl_out[1];
   assign d_sel[8] = port_d_function_control_high[pin_mux_pkg::POS_D8];
   assign d_periph_out[8] = pulse_ctrl_out[0];

   generate
      for (i = 0; i < pin_mux_pkg::PORT_D_PINS; i++)
      begin : g_port_d
         assign port_d_gpio_in[i] = port_d_pad_in[i];
         if (i < pin_mux_pkg::PORT_D_LOW_PINS)
         begin : g_low
            assign d_sel[i] = port_d_function_control_low[2 * i];
            assign d_periph_out[i] = timer_io_out[i];
            assign timer_io_in[i] = d_sel[i] ? port_d_pad_in[i] : 1'b0;
            assign port_d_pad_oe[i] = port_d_direction[i];
         end
         else
         begin : g_high
            assign port_d_pad_oe[i] = d_sel[i] ? 1'b1 : port_d_direction[i];
         end
         assign port_d_pad_out[i] = d_sel[i] ? d_periph_out[i] : port_d_gpio_out[i];
      end
   endgenerate
endmodule // port_c_d_pin_function_select
`default_nettype wire

/* File: verif/pin_mux_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_mux_sva (
   // clock, reset, bus
   input wire logic clk, rst_b, hw_standby, wr, rd,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata, rdata,
   // port c
   input wire logic [4:0] port_c_pad_in, port_c_pad_out, port_c_pad_oe,
   input wire logic external_interrupt_in_0, serial1_receive_in,
   input wire logic serial1_transmit_out, serial2_transmit_out,
   // port d
   input wire logic [6:0] pulse_ctrl_out,
   input wire logic [13:0] port_d_pad_out, port_d_pad_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence c_set(int b);
      wr && !hw_standby && addr == 3'h1 && wdata[b];
   endsequence
   sequence d_set(int b);
      wr && !hw_standby && addr == 3'h3 && wdata[b];
   endsequence
   a_c0_tx_route: assert property (c_set(0) |=>
      port_c_pad_oe[0] && port_c_pad_out[0] == serial1_transmit_out) else $error("c0 tx");
   a_c2_tx_route: assert property (c_set(4) |=>
      port_c_pad_oe[2] && port_c_pad_out[2] == serial2_transmit_out) else $error("c2 tx");
   a_c1_rx_route: assert property (c_set(2) |=>
      !port_c_pad_oe[1] && serial1_receive_in == port_c_pad_in[1]) else $error("c1 rx");
   a_irq_route: assert property (c_set(8) |=>
      external_interrupt_in_0 == port_c_pad_in[4]) else $error("c4 irq");
   a_d12_pulse_route: assert property (d_set(8) |=>
      port_d_pad_oe[12] && port_d_pad_out[12] == pulse_ctrl_out[4]) else $error("d12");
   a_d8_pulse_route: assert property (d_set(0) |=>
      port_d_pad_oe[8] && port_d_pad_out[8] == pulse_ctrl_out[0]) else $error("d8");
   a_c_reserved_zero: assert property (rd && addr == 3'h1 |=>
      (rdata & 16'hfeaa) == 16'h0000) else $error("c reserved bits");
   a_d_dir_top: assert property (rd && addr == 3'h2 |=>
      rdata[15:14] == 2'b00) else $error("d direction top bits");
   a_standby_clear: assert property (hw_standby |=>
      port_c_pad_oe == 5'h00 && port_d_pad_oe == 14'h0000) else $error("standby");
endmodule // pin_mux_sva
bind port_c_d_pin_function_select pin_mux_sva chk (.clk, .rst_b, .hw_standby, .wr, .rd,
   .addr, .wdata, .rdata, .port_c_pad_in, .port_c_pad_out, .port_c_pad_oe,
   .external_interrupt_in_0, .serial1_receive_in, .serial1_transmit_out,
   .serial2_transmit_out, .pulse_ctrl_out, .port_d_pad_out, .port_d_pad_oe);
`default_nettype wire

/* File: verif/pad_env.sv */
`timescale 1ns/10ps
`default_nettype none
module pad_env (
   input wire logic clk, rst_b,
   input wire logic [4:0] c_out, c_oe,
   input wire logic [13:0] d_out, d_oe,
   output logic [4:0] c_in,
   output logic [13:0] d_in,
   output logic s1_tx, s2_tx, can_tx,
   output logic [6:0] pulse
);
   logic ph;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b) ph <= 1'b0;
      else ph <= ~ph;
   // peripherals toggle so routing is visible
   assign pulse = {7{ph}} ^ 7'h35;
   assign s1_tx = ph;
   assign s2_tx = ~ph;
   assign can_tx = ~ph;
   assign c_in = (c_oe & c_out) | (~c_oe & ({5{ph}} ^ 5'h0b));
   assign d_in = (d_oe & d_out) | (~d_oe & ({14{ph}} ^ 14'h2a5c));
endmodule // pad_env
`default_nettype wire

/* File: verif/test_port_c_d_pin_function_select.sv */
`timescale 1ns/10ps
`default_nettype none
module test_port_c_d_pin_function_select;
   logic clk = 0, rst_b = 0, hw_standby = 0, wr = 0, rd = 0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic [4:0] port_c_gpio_out = 5'h16, port_c_gpio_in, port_c_pad_in, port_c_pad_out, port_c_pad_oe;
   logic external_interrupt_in_0, serial1_receive_in, serial2_receive_in;
   logic serial1_transmit_out, serial2_transmit_out, can_transmit_out;
   logic [13:0] port_d_gpio_out = 14'h1c3a, port_d_gpio_in, port_d_pad_in, port_d_pad_out;
   logic [13:0] port_d_pad_oe;
   logic [7:0] timer_io_out = 8'ha5, timer_io_in;
   logic [6:0] pulse_ctrl_out;
   int n_mismatch = 0, total_checks = 0, cycles = 0;
   port_c_d_pin_function_select uut (.*);
   pad_env far (.clk, .rst_b, .c_out(port_c_pad_out), .c_oe(port_c_pad_oe),
      .d_out(port_d_pad_out), .d_oe(port_d_pad_oe), .c_in(port_c_pad_in),
      .d_in(port_d_pad_in), .s1_tx(serial1_transmit_out), .s2_tx(serial2_transmit_out),
      .can_tx(can_transmit_out), .pulse(pulse_ctrl_out));
   always #25 clk = ~clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rreg(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic t_masks;
      logic [15:0] m [6];
      logic [15:0] w;
      m = '{pin_mux_pkg::MASK_PORT_C_DIRECTION, pin_mux_pkg::MASK_PORT_C_FUNCTION_CONTROL,
         pin_mux_pkg::MASK_PORT_D_DIRECTION, pin_mux_pkg::MASK_PORT_D_FUNCTION_CONTROL_HIGH,
         pin_mux_pkg::MASK_PORT_D_FUNCTION_CONTROL_LOW, 16'h0000};
      for (int a = 0; a < 6; a++)
      begin
         w = (a == 3) ? 16'hf7ff : 16'hffff;
         rreg(3'(a), v);
         chk("reset value", 16'h0000, v);
         wreg(3'(a), w);
         rreg(3'(a), v);
         chk("writable bits", m[a] & w, v);
         wreg(3'(a), 16'h0000);
      end
   endtask
   task automatic t_port_c;
      wreg(3'h0, 16'h001f);
      chk("c gpio drive", {6'h00, 5'h1f, port_c_gpio_out}, {6'h00, port_c_pad_oe, port_c_pad_out});
      wreg(3'h1, 16'h0155);
      wreg(3'h0, 16'h0000);
      chk("c oe", 16'h0005, {11'h000, port_c_pad_oe});
      repeat (2)
      begin
         @(negedge clk);
         chk("c tx", {14'h0, serial2_transmit_out, serial1_transmit_out},
            {14'h0, port_c_pad_out[2], port_c_pad_out[0]});
         chk("c rx", {13'h0, port_c_pad_in[4], port_c_pad_in[3], port_c_pad_in[1]},
            {13'h0, external_interrupt_in_0, serial2_receive_in, serial1_receive_in});
         chk("c gpio in", {11'h000, port_c_pad_in}, {11'h000, port_c_gpio_in});
      end
   endtask
   task automatic t_port_d;
      wreg(3'h2, 16'h3fff);
      chk("d dir out", {2'b00, port_d_gpio_out}, {2'b00, port_d_pad_out});
      chk("d oe out", 16'h3fff, {2'b00, port_d_pad_oe});
      wreg(3'h4, 16'h0001);
      chk("d0 timer", {8'h00, 7'h00, timer_io_out[0]}, {8'h00, 7'h00, port_d_pad_out[0]});
      wreg(3'h2, 16'h0000);
      repeat (2)
      begin
         @(negedge clk);
         chk("d0 timer in", {15'h0, port_d_pad_in[0]}, {15'h0, timer_io_in[0]});
         chk("d0 timer oe", 16'h0000, {15'h0, port_d_pad_oe[0]});
         chk("d gpio in", {2'b00, port_d_pad_in}, {2'b00, port_d_gpio_in});
      end
      wreg(3'h3, 16'h0555);
      chk("d high oe", 16'h3f00, {2'b00, port_d_pad_oe});
      chk("d pulse", {10'h0, pulse_ctrl_out[6], pulse_ctrl_out[4:0]},
         {10'h0, port_d_pad_out[13:8]});
      wreg(3'h3, 16'h0800);
      chk("d13 can", {15'h0, can_transmit_out}, {15'h0, port_d_pad_out[13]});
   endtask
   task automatic t_standby;
      wreg(3'h1, 16'h0155);
      wreg(3'h2, 16'h0011);
      rreg(3'h3, v);
      chk("held value", 16'h0800, v);
      @(posedge clk);
      hw_standby <= 1'b1;
      @(posedge clk);
      hw_standby <= 1'b0;
      rreg(3'h1, v);
      chk("standby c", 16'h0000, v);
      rreg(3'h3, v);
      chk("standby d", 16'h0000, v);
      rreg(3'h2, v);
      chk("standby d dir", 16'h0000, v);
   endtask
   task give_verdict;
      if (n_mismatch == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_masks();
      t_port_c();
      t_port_d();
      t_standby();
      give_verdict();
   end
endmodule // test_port_c_d_pin_function_select
`default_nettype wire
